// *** sfd_pkg.sv ***
/*
 * shared constants, word-size decoding and state type of the serial unit.
 * assumes a single 20 MHz clock domain for every user of these names.
 */
package sfd_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 5;
    localparam int EDGE_W = 6;
    localparam int DIV_W = 8;
    localparam int DIVCNT_W = 9;
    localparam int SYNC_W = 3;
    localparam int QUEUE_DEPTH = 2;

    // ****************************************************************
    // values
    // ****************************************************************
    localparam logic [CNT_W-1:0] NARROW_MAX = 5'h08;
    localparam logic [CNT_W-1:0] FULL_BITS = 5'h10;
    localparam logic [CNT_W-1:0] ONE_CNT = 5'h01;
    localparam logic [EDGE_W-1:0] ONE_EDGE = 6'h01;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h4;
    localparam int SYNC_SSN = 2;
    localparam int SYNC_SCK = 1;
    localparam int SYNC_SIN = 0;
    localparam logic [2:0] WS_6 = 3'h0;
    localparam logic [2:0] WS_7 = 3'h1;
    localparam logic [2:0] WS_8 = 3'h2;
    localparam logic [2:0] WS_9 = 3'h3;
    localparam logic [2:0] WS_12 = 3'h4;
    localparam logic [2:0] WS_14 = 3'h5;
    localparam logic [2:0] WS_16 = 3'h6;

    typedef enum {SFD_IDLE, SFD_ACTIVE} sfd_state_t;

    // ****************************************************************
    // word size code to bit count
    // ****************************************************************
    function automatic logic [CNT_W-1:0] word_bits(input logic [2:0] code);
        case (code)
            WS_6: word_bits = 5'h06;
            WS_7: word_bits = 5'h07;
            WS_8: word_bits = 5'h08;
            WS_9: word_bits = 5'h09;
            WS_12: word_bits = 5'h0C;
            WS_14: word_bits = 5'h0E;
            WS_16: word_bits = 5'h10;
            default: word_bits = 5'h08;
        endcase
    endfunction

endpackage

// *** sfd_two_entry_buf.sv ***
/*
 * small first-in first-out buffer with valid/ready on both sides.
 * assumes both sides run on clk; outputs reset to empty.
 */
`timescale 1ns/1ps
module sfd_two_entry_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wrPtr_r;
    logic [PTR_W-1:0] rdPtr_r;
    logic [CNT_W-1:0] count_r;
    logic push;
    logic pop;

    assign inReady = (count_r != FULL_CNT);
    assign outValid = (count_r != '0);
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign outData = mem_r[rdPtr_r];

    // ****************************************************************
    // storage, one write port per entry
    // ****************************************************************
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_ff @(posedge clk) begin
            if (srst) begin
                mem_r[g] <= '0;
            end else if (push && wrPtr_r == PTR_W'(g)) begin
                mem_r[g] <= inData;
            end
        end
    end

    // ****************************************************************
    // pointers and fill level
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

// *** sfd_spi_unit.sv ***
/*
 * serial peripheral unit: byte-wide data access, transmit and receive
 * queues, master clock divider, shifter, status and error flags.
 * assumes control ports are static during a word and that the serial
 * pins come from outside the clock domain.
 */
`timescale 1ns/1ps
// How it works
// RQ1 - words of eight bits or fewer use only the low data byte
// RQ2 - wider words: software accesses low byte first, then high byte
// RQ3 - wide words: transmit queue levels change only on high byte write
// RQ4 - wide words: receive queue levels change only on high byte read
// RQ5 - transmit interrupt: space with enable, done with enable, errors with enable
// RQ6 - transmit full sets when queue fills, clears when a transmission starts
// RQ7 - transmit underflow sets when a word starts with queue empty; write one clears
// RQ8 - transmit overflow sets on write into a full queue; write one clears
// RQ9 - transfer done sets when a word ends with queue empty; write one clears
// RQ10 - receive interrupt: data with enable, or errors with enable
// RQ11 - receive empty clears when a word arrives, sets once all are read
// RQ12 - receive underflow sets on low byte read of empty queue; write one clears
// RQ13 - receive overflow sets when a word ends with queue full; write one clears
// RQ14 - master: a word written to an empty queue loads the shifter and starts
// RQ15 - two successive writes make the transmit queue full; an enabled idle master moves the first into the shifter, so three fill it
// RQ16 - master receive needs a dummy write to produce serial clocks
// RQ17 - master word ends at last clock edge and sets the completion flag
// RQ18 - master: software drives slave selects through general pins
// RQ19 - slave works only while select input is low; clock is an input
// RQ20 - slave shifts on incoming clock edges, loading from the transmit queue
// RQ21 - slave word ends at the last expected clock edge, setting completion; code ends it at the last sample edge, one edge early with phase zero
// RQ22 - size codes pick 6,7,8,9,12,14,16 bits; code seven is reserved
// RQ23 - master clock is system clock over four times divider plus one
// RQ24 - polarity and phase choose which edge launches and which samples
// RQ25 - slave underflow only with transmit enabled; else queue is untouched
// RQ26 - writing zero leaves flags alone; interrupts are plain levels
// RQ27 - receive queue holds two words and reports full when it cannot store
module sfd_spi_unit (
    input wire logic clk,
    input wire logic srst,
    input wire logic coreEnable,
    input wire logic masterMode,
    input wire logic clockPolarity,
    input wire logic clockPhase,
    input wire logic transmitEnable,
    input wire logic receiveEnable,
    input wire logic lsbFirst,
    input wire logic [2:0] wordSize,
    input wire logic [sfd_pkg::DIV_W-1:0] sckDivider,
    input wire logic txSpaceIrqEn,
    input wire logic transferDoneIrqEn,
    input wire logic txErrorIrqEn,
    input wire logic rxAvailIrqEn,
    input wire logic rxErrorIrqEn,
    input wire logic dataWr,
    input wire logic dataRd,
    input wire logic dataHighSel,
    input wire logic [sfd_pkg::BYTE_W-1:0] wrData,
    output logic [sfd_pkg::BYTE_W-1:0] rdData,
    input wire logic clrTransferDone,
    input wire logic clrTransferComplete,
    input wire logic clrTxUnderflow,
    input wire logic clrTxOverflow,
    input wire logic clrRxUnderflow,
    input wire logic clrRxOverflow,
    output logic txQueueEmpty,
    output logic txQueueFull,
    output logic rxQueueEmpty,
    output logic rxQueueFull,
    output logic transferDone,
    output logic transferCompleteFlag,
    output logic txUnderflowErr,
    output logic txOverflowErr,
    output logic rxUnderflowErr,
    output logic rxOverflowErr,
    output logic intTx,
    output logic intRx,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOe,
    input wire logic slaveSelN
);
    localparam int DW = sfd_pkg::DATA_W;
    localparam int BW = sfd_pkg::BYTE_W;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [sfd_pkg::SYNC_W-1:0] meta_r;
    logic [sfd_pkg::SYNC_W-1:0] sync_r;
    logic sckPrev_r;
    logic ssnSync;
    logic sckSync;
    logic sinSync;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= sfd_pkg::SYNC_RESET;
            sync_r <= sfd_pkg::SYNC_RESET;
            sckPrev_r <= 1'b0;
        end else begin
            meta_r <= {slaveSelN, sckIn, serialIn};
            sync_r <= meta_r;
            sckPrev_r <= sync_r[sfd_pkg::SYNC_SCK];
        end
    end

    assign ssnSync = sync_r[sfd_pkg::SYNC_SSN];
    assign sckSync = sync_r[sfd_pkg::SYNC_SCK];
    assign sinSync = sync_r[sfd_pkg::SYNC_SIN];

    // ****************************************************************
    // word size and data byte access
    // ****************************************************************
    logic [sfd_pkg::CNT_W-1:0] wordBits;
    logic wide;
    logic dataLowByteWr;
    logic dataHighByteWr;
    logic dataLowByteRd;
    logic dataHighByteRd;
    logic [BW-1:0] lowHold_r;
    logic txPushReq;
    logic [DW-1:0] txPushData;
    logic txInReady;
    logic txOutValid;
    logic txOutReady;
    logic [DW-1:0] txOutData;
    logic rxPushReq;
    logic [DW-1:0] rxPushData;
    logic rxInReady;
    logic rxOutValid;
    logic rxPopReq;
    logic [DW-1:0] rxOutData;

    assign wordBits = sfd_pkg::word_bits(wordSize); // see RQ22
    assign wide = (wordBits > sfd_pkg::NARROW_MAX);
    assign dataLowByteWr = dataWr & ~dataHighSel;
    assign dataHighByteWr = dataWr & dataHighSel;
    assign dataLowByteRd = dataRd & ~dataHighSel;
    assign dataHighByteRd = dataRd & dataHighSel;
    // narrow words ignore the high byte; wide words commit on high byte
    assign txPushReq = wide ? dataHighByteWr : dataLowByteWr; // see RQ1 see RQ3
    assign txPushData = wide ? {wrData, lowHold_r} : {{BW{1'b0}}, wrData};
    assign rxPopReq = wide ? dataHighByteRd : dataLowByteRd; // see RQ1 see RQ4

    always_ff @(posedge clk) begin
        if (srst) begin
            lowHold_r <= '0;
        end else if (dataLowByteWr) begin
            lowHold_r <= wrData; // see RQ2
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdData <= '0;
        end else if (dataLowByteRd) begin
            rdData <= rxOutValid ? rxOutData[BW-1:0] : '0;
        end else if (dataHighByteRd) begin
            rdData <= rxOutValid ? rxOutData[DW-1:BW] : '0;
        end
    end

    // ****************************************************************
    // queues
    // ****************************************************************
    sfd_two_entry_buf #(.WIDTH(DW), .DEPTH(sfd_pkg::QUEUE_DEPTH)) txQueue (
        .clk(clk),
        .srst(srst),
        .inValid(txPushReq),
        .inReady(txInReady),
        .inData(txPushData),
        .outValid(txOutValid),
        .outReady(txOutReady),
        .outData(txOutData)
    ); // see RQ15

    sfd_two_entry_buf #(.WIDTH(DW), .DEPTH(sfd_pkg::QUEUE_DEPTH)) rxQueue (
        .clk(clk),
        .srst(srst),
        .inValid(rxPushReq),
        .inReady(rxInReady),
        .inData(rxPushData),
        .outValid(rxOutValid),
        .outReady(rxPopReq),
        .outData(rxOutData)
    ); // see RQ27

    assign txQueueEmpty = ~txOutValid;
    assign txQueueFull = ~txInReady; // see RQ6
    assign rxQueueEmpty = ~rxOutValid; // see RQ11
    assign rxQueueFull = ~rxInReady;

    // ****************************************************************
    // clock edges for both modes
    // ****************************************************************
    sfd_pkg::sfd_state_t state_r;
    logic [sfd_pkg::DIVCNT_W-1:0] divCnt_r;
    logic [sfd_pkg::EDGE_W-1:0] edgeCnt_r;
    logic [sfd_pkg::CNT_W-1:0] sampleCnt_r;
    logic [DW-1:0] txShift_r;
    logic [DW-1:0] rxShift_r;
    logic active;
    logic tick;
    logic sckEdge;
    logic newLevel;
    logic leading;
    logic sampleEdge;
    logic setupEdge;
    logic [sfd_pkg::EDGE_W-1:0] lastEdge;
    logic wordDone;
    logic slaveAbort;
    logic startOk;
    logic txLoad;

    assign active = (state_r == sfd_pkg::SFD_ACTIVE);
    // half period is two times divider plus two system clocks
    assign tick = active & masterMode & (divCnt_r == {sckDivider, 1'b1}); // see RQ23
    assign sckEdge = masterMode ? tick : active & (sckSync != sckPrev_r); // see RQ19
    assign newLevel = masterMode ? ~sckOut : sckSync;
    assign leading = (newLevel != clockPolarity);
    assign sampleEdge = sckEdge & (leading ^ clockPhase); // see RQ24
    assign setupEdge = sckEdge & ~(leading ^ clockPhase) & (sampleCnt_r != '0);
    assign lastEdge = sfd_pkg::EDGE_W'({wordBits, 1'b0} - sfd_pkg::ONE_EDGE);
    assign wordDone = masterMode ? tick & (edgeCnt_r == lastEdge) // see RQ17
        : sampleEdge & (sampleCnt_r == wordBits - sfd_pkg::ONE_CNT); // see RQ21
    assign slaveAbort = active & ~masterMode & ssnSync;
    assign startOk = coreEnable & (transmitEnable | receiveEnable) & ~active
        & (masterMode ? txOutValid : ~ssnSync); // see RQ14 see RQ16 see RQ19
    assign txLoad = startOk & (masterMode | transmitEnable); // see RQ25
    assign txOutReady = txLoad;

    // ****************************************************************
    // shift data
    // ****************************************************************
    logic [3:0] topIdx;
    logic [DW-1:0] rxShiftNxt;
    logic [DW-1:0] rxCapture;
    logic [DW-1:0] rxMask;

    assign topIdx = 4'(wordBits - sfd_pkg::ONE_CNT);
    assign rxShiftNxt = lsbFirst ? {sinSync, rxShift_r[DW-1:1]} : {rxShift_r[DW-2:0], sinSync};
    assign rxCapture = sampleEdge ? rxShiftNxt : rxShift_r;
    assign rxMask = DW'(({1'b0, {DW{1'b1}}} << wordBits) ^ {1'b0, {DW{1'b1}}}) ;
    assign rxPushData = lsbFirst ? rxCapture >> (sfd_pkg::FULL_BITS - wordBits) : rxCapture & rxMask;
    assign rxPushReq = wordDone & receiveEnable;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= sfd_pkg::SFD_IDLE;
        end else if (~coreEnable || wordDone || slaveAbort) begin
            state_r <= sfd_pkg::SFD_IDLE;
        end else if (startOk) begin
            state_r <= sfd_pkg::SFD_ACTIVE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !active || tick) begin
            divCnt_r <= '0;
        end else begin
            divCnt_r <= divCnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sckOut <= 1'b0;
        end else if (tick) begin
            sckOut <= ~sckOut;
        end else if (!active) begin
            sckOut <= clockPolarity;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || startOk) begin
            edgeCnt_r <= '0;
            sampleCnt_r <= '0;
        end else begin
            if (sckEdge) begin
                edgeCnt_r <= edgeCnt_r + 1'b1;
            end
            if (sampleEdge) begin
                sampleCnt_r <= sampleCnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            txShift_r <= '0;
        end else if (startOk) begin
            txShift_r <= (txLoad && txOutValid) ? txOutData : '0; // see RQ20
        end else if (setupEdge) begin
            txShift_r <= lsbFirst ? {1'b0, txShift_r[DW-1:1]} : {txShift_r[DW-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (srst || startOk) begin
            rxShift_r <= '0;
        end else if (sampleEdge) begin
            rxShift_r <= rxShiftNxt; // see RQ20
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            serialOut <= 1'b0;
        end else begin
            serialOut <= lsbFirst ? txShift_r[0] : txShift_r[topIdx];
        end
    end

    assign sckOe = coreEnable & masterMode;
    assign serialOe = coreEnable & (masterMode | ~ssnSync);

    // ****************************************************************
    // status and error flags, set wins over clear
    // ****************************************************************
    logic doneSet;
    logic txUnderSet;
    logic txOverSet;
    logic rxUnderSet;
    logic rxOverSet;

    assign doneSet = wordDone & ~txOutValid; // see RQ9
    assign txUnderSet = startOk & ~masterMode & transmitEnable & ~txOutValid; // see RQ7 see RQ25
    assign txOverSet = txPushReq & ~txInReady; // see RQ8
    assign rxUnderSet = dataLowByteRd & ~rxOutValid; // see RQ12
    assign rxOverSet = rxPushReq & ~rxInReady; // see RQ13

    always_ff @(posedge clk) begin
        if (srst) begin
            transferDone <= 1'b0;
            transferCompleteFlag <= 1'b0;
            txUnderflowErr <= 1'b0;
            txOverflowErr <= 1'b0;
            rxUnderflowErr <= 1'b0;
            rxOverflowErr <= 1'b0;
        end else begin
            transferDone <= doneSet | (transferDone & ~clrTransferDone); // see RQ26
            transferCompleteFlag <= wordDone | (transferCompleteFlag & ~clrTransferComplete);
            txUnderflowErr <= txUnderSet | (txUnderflowErr & ~clrTxUnderflow);
            txOverflowErr <= txOverSet | (txOverflowErr & ~clrTxOverflow);
            rxUnderflowErr <= rxUnderSet | (rxUnderflowErr & ~clrRxUnderflow);
            rxOverflowErr <= rxOverSet | (rxOverflowErr & ~clrRxOverflow);
        end
    end

    // ****************************************************************
    // interrupt levels
    // ****************************************************************
    assign intTx = (~txQueueFull & txSpaceIrqEn) | (transferDone & transferDoneIrqEn)
        | ((txUnderflowErr | txOverflowErr) & txErrorIrqEn); // see RQ5 see RQ26
    assign intRx = (~rxQueueEmpty & rxAvailIrqEn)
        | ((rxUnderflowErr | rxOverflowErr) & rxErrorIrqEn); // see RQ10

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_TX_OVERFLOW: assert property ( // see RQ8
        txPushReq && txQueueFull && !clrTxOverflow |=> txOverflowErr)
        else $error("overflow flag missed");
    AST_RX_UNDERFLOW: assert property ( // see RQ12
        dataLowByteRd && rxQueueEmpty && !clrRxUnderflow |=> rxUnderflowErr)
        else $error("underflow flag missed");
    AST_FLAG_HOLD: assert property ( // see RQ26
        rxOverflowErr && !clrRxOverflow |=> rxOverflowErr)
        else $error("flag dropped without clear");
    AST_DONE_FLAG: assert property ( // see RQ9
        wordDone && txQueueEmpty |=> transferDone && transferCompleteFlag)
        else $error("transfer end not flagged");
    AST_NARROW_HIGH: assert property ( // see RQ1
        dataHighByteWr && !wide && !txOutReady |=> $stable(txQueueEmpty) && $stable(txQueueFull))
        else $error("high byte changed narrow queue");
    AST_WIDE_LOWRD: assert property ( // see RQ4
        dataLowByteRd && wide && !rxPushReq |=> $stable(rxQueueEmpty))
        else $error("low byte read popped wide word");
    AST_RX_ARRIVE: assert property ( // see RQ11
        rxPushReq && !rxQueueFull |=> !rxQueueEmpty)
        else $error("received word not visible");
    AST_TICK_SPACE: assert property ( // see RQ23
        tick |=> !tick ##1 (sckDivider == '0 || !tick))
        else $error("serial clock half period too short");
    AST_INT_TX: assert property ( // see RQ5
        !txQueueFull && txSpaceIrqEn |-> intTx)
        else $error("transmit interrupt missing");

endmodule

// *** sfd_spi_partner.sv ***
/* far-side slave model for master runs: mode 0, msb first.
   assumes the bench drives its select and the clock idles low. */
`timescale 1ns/1ps
module sfd_spi_partner (
    input wire logic sck,
    input wire logic mosi,
    input wire logic selN,
    input wire logic [15:0] reply,
    input wire logic [4:0] bits,
    output logic miso,
    output logic [15:0] got
);
    logic [15:0] sh;
    initial miso = 1'h0;
    always @(negedge selN) begin
        sh = reply << (5'h10 - bits);
        got = 16'h0000;
        miso = sh[15];
    end
    always @(posedge sck) begin
        if (!selN)
            got = {got[14:0], mosi};
    end
    always @(negedge sck) begin
        if (!selN) begin
            sh = sh << 1;
            miso = sh[15];
        end
    end
    // released line shows the inverse of its last bit
    always @(posedge selN) miso = ~miso;
endmodule

// *** sfd_spi_unit_tb.sv ***
/* bench of the serial unit: master runs against the partner, slave runs from the bench.
   assumes sfd_pkg, sfd_spi_unit and sfd_spi_partner are compiled first. */
`timescale 1ns/1ps
module sfd_spi_unit_tb;
    logic clk, srst, coreEnable, masterMode, clockPolarity, clockPhase, lsbFirst, transmitEnable;
    logic receiveEnable, dataWr, dataRd, dataHighSel, sckIn, slaveSelN, pSelN, pMiso, tbMosi;
    logic txSpaceIrqEn, transferDoneIrqEn, txErrorIrqEn, rxAvailIrqEn, rxErrorIrqEn;
    logic clrTransferDone, clrTransferComplete, clrTxUnderflow, clrTxOverflow, clrRxUnderflow;
    logic clrRxOverflow, txQueueEmpty, txQueueFull, rxQueueEmpty, rxQueueFull, transferDone;
    logic transferCompleteFlag, txUnderflowErr, txOverflowErr, rxUnderflowErr, rxOverflowErr;
    logic intTx, intRx, sckOut, sckOe, serialIn, serialOut, serialOe;
    logic [2:0] wordSize;
    logic [4:0] pBits;
    logic [5:0] clrs;
    logic [7:0] sckDivider, wrData, rdData, sGot;
    logic [15:0] reply, pGot;
    int failures, checks_done;
    assign {clrTransferDone, clrTransferComplete, clrTxUnderflow} = clrs[5:3];
    assign {clrTxOverflow, clrRxUnderflow, clrRxOverflow} = clrs[2:0];
    assign serialIn = masterMode ? pMiso : tbMosi;
    assign pBits = (wordSize == 3'h6) ? 5'h10 : 5'h08;
    sfd_spi_unit uut (.*);
    sfd_spi_partner partner (.sck(sckOut), .mosi(serialOut), .selN(pSelN), .reply(reply), .bits(pBits),
        .miso(pMiso), .got(pGot));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic nop(input int n);
        repeat (n) begin
            @(posedge clk);
            dataWr <= 1'h0;
            dataRd <= 1'h0;
            clrs <= 6'h00;
        end
        @(negedge clk);
    endtask
    task automatic wr(input logic hi, input logic [7:0] d);
        @(posedge clk);
        dataWr <= 1'h1;
        dataHighSel <= hi;
        wrData <= d;
    endtask
    task automatic rd(input logic hi);
        @(posedge clk);
        dataRd <= 1'h1;
        dataHighSel <= hi;
        nop(1);
    endtask
    task automatic clrAll();
        @(posedge clk);
        clrs <= 6'h3F;
        nop(1);
    endtask
    task automatic waitDone();
        int i;
        for (i = 0; i < 3000 && transferCompleteFlag !== 1'h1; i++)
            @(posedge clk);
        if (i == 3000) begin
            failures++;
            summarize();
        end
        @(posedge clk);
        clrs <= 6'h10;
        nop(2);
    endtask
    task automatic selPulse();
        @(posedge clk);
        pSelN <= 1'h1;
        @(posedge clk);
        pSelN <= 1'h0;
    endtask
    task automatic slaveWord(input logic [7:0] w);
        @(posedge clk);
        slaveSelN <= 1'h0;
        for (int i = 7; i >= 0; i--) begin
            repeat (6) @(posedge clk);
            tbMosi <= w[i];
            repeat (6) @(posedge clk);
            sckIn <= 1'h1;
            sGot <= {sGot[6:0], serialOut};
            repeat (6) @(posedge clk);
            sckIn <= 1'h0;
        end
        repeat (6) @(posedge clk);
        slaveSelN <= 1'h1;
        nop(4);
    endtask
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial begin
        {srst, coreEnable, masterMode, transmitEnable, receiveEnable, slaveSelN, pSelN} = 7'h7F;
        {clockPolarity, clockPhase, lsbFirst, dataWr, dataRd, dataHighSel, sckIn, tbMosi} = 8'h00;
        {txSpaceIrqEn, transferDoneIrqEn, txErrorIrqEn, rxAvailIrqEn, rxErrorIrqEn} = 5'h00;
        {clrs, wordSize, sckDivider, wrData, reply} = {6'h00, 3'h2, 8'h03, 8'h00, 16'h003C};
        failures = 0;
        checks_done = 0;
        repeat (12) @(posedge clk);
        srst <= 1'h0;
        nop(1);
        chk({sckOe, serialOe, txQueueEmpty, txQueueFull, rxQueueEmpty, rxQueueFull, intTx, intRx, transferDone,
            transferCompleteFlag, txUnderflowErr, txOverflowErr, rxUnderflowErr, rxOverflowErr}, 16'h3A00);
        $display("test 1 done");
        selPulse();
        {transferDoneIrqEn, rxAvailIrqEn} <= 2'h3;
        wr(1'h1, 8'h55);
        nop(2);
        chk({txQueueEmpty, transferCompleteFlag}, 16'h0002);
        wr(1'h0, 8'hA5);
        nop(1);
        waitDone();
        chk(pGot[7:0], 16'h00A5);
        chk({transferDone, rxQueueEmpty, intTx, intRx}, 16'h000B);
        rd(1'h0);
        chk({rxQueueEmpty, intRx, rdData}, 16'h023C);
        clrAll();
        chk({transferDone, intTx}, 16'h0000);
        $display("test 2 done");
        selPulse();
        {txSpaceIrqEn, rxErrorIrqEn} <= 2'h3;
        for (int k = 1; k < 5; k++)
            wr(1'h0, 8'(8'hA0 + k));
        nop(2);
        chk({txQueueFull, txOverflowErr, intTx}, 16'h0006);
        @(posedge clk);
        txErrorIrqEn <= 1'h1;
        nop(1);
        chk(intTx, 16'h0001);
        waitDone();
        chk(txQueueFull, 16'h0000);
        waitDone();
        waitDone();
        chk({rxQueueFull, rxOverflowErr, pGot[7:0]}, 16'h03A3);
        rd(1'h0);
        chk(rdData, 16'h003C);
        rd(1'h0);
        chk(rdData, 16'h0000);
        rd(1'h0);
        chk({rxUnderflowErr, rxQueueEmpty, intRx, rdData}, 16'h0700);
        clrAll();
        chk({rxUnderflowErr, rxOverflowErr, txOverflowErr, intRx}, 16'h0000);
        $display("test 3 done");
        @(posedge clk);
        {wordSize, sckDivider, reply} <= {3'h6, 8'h01, 16'hBEEF};
        selPulse();
        wr(1'h0, 8'h34);
        nop(2);
        chk({txQueueEmpty, transferCompleteFlag}, 16'h0002);
        wr(1'h1, 8'h12);
        nop(1);
        waitDone();
        chk(pGot, 16'h1234);
        rd(1'h0);
        chk({rxQueueEmpty, rdData}, 16'h00EF);
        rd(1'h1);
        chk({rxQueueEmpty, rdData}, 16'h01BE);
        $display("test 4 done");
        @(posedge clk);
        {masterMode, wordSize} <= 4'h2;
        clrAll();
        slaveWord(8'h96);
        chk({txUnderflowErr, transferCompleteFlag, sckOe, serialOe}, 16'h000C);
        rd(1'h0);
        chk(rdData, 16'h0096);
        wr(1'h0, 8'hC3);
        nop(1);
        slaveWord(8'h5A);
        rd(1'h0);
        chk({sGot, rdData}, 16'hC35A);
        @(posedge clk);
        {transmitEnable, clockPhase, lsbFirst} <= 3'h3;
        clrAll();
        slaveWord(8'h96);
        chk({txUnderflowErr, transferCompleteFlag}, 16'h0001);
        rd(1'h0);
        chk(rdData, 16'h0069);
        $display("test 5 done");
        summarize();
    end
endmodule
